// [src/pdp_pkg.sv]
/*
  Shared constants and types of the synthesizer frequency path control:
  register offsets, reset values, field layouts, divider limits and the
  output-bus selection codes.
  Assumes a register port with 8-bit addresses and 24-bit data.
*/
package pdp_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;

  localparam logic [7:0] OFF_REF_CFG = 8'h01;
  localparam logic [7:0] OFF_REF_DIV = 8'h03;
  localparam logic [7:0] OFF_N_RATIO = 8'h05;
  localparam logic [7:0] OFF_FRAC = 8'h06;
  localparam logic [7:0] OFF_MODE = 8'h07;
  localparam logic [7:0] OFF_STATUS = 8'h0A;
  localparam logic [7:0] OFF_GPO = 8'h1B;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dsm_sin_sel;
    logic sqr_todig_en;
    logic sin_sel;
    logic div_en;
    logic square_buffer_enable;
    logic sin_buf_en;
  } pdp_ref_cfg_t;

  typedef struct packed {
    logic auto_sel;
    logic out_sel;
    logic [13:0] ratio;
  } pdp_ref_div_t;

  typedef struct packed {
    logic [2:0] data;
    logic [3:0] sel;
  } pdp_gpo_cfg_t;

  // Pins that arrive from outside the clock domain.
  typedef struct packed {
    logic vco;
    logic sq_ref;
    logic sine_reference_pin;
    logic lock_win;
    logic pfd_up;
    logic pfd_dn;
    logic ref_fast;
    logic vco_fast;
    logic pfd_strobe;
    logic aux_clk;
    logic ring_osc;
    logic [2:0] vco_le;
  } pdp_pins_t;

  localparam int PINS_W = $bits(pdp_pins_t);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] REF_CFG_RST = 6'h02;
  localparam logic [15:0] REF_DIV_RST = 16'h8001;
  localparam logic [16:0] N_RATIO_RST = 17'h00064;
  localparam logic [23:0] FRAC_RST = 24'h000000;
  localparam logic [6:0] GPO_RST = 7'h00;

  // ----------------------------------------------------------------
  // Divider limits
  // ----------------------------------------------------------------
  localparam logic [13:0] REF_RATIO_ONE = 14'h0001;
  localparam logic [16:0] N_FRAC_MIN = 17'h00048;
  localparam logic [16:0] N_FRAC_MAX = 17'h1FFF6;
  localparam logic [16:0] N_INT_MIN = 17'h00040;
  localparam logic [16:0] N_INT_MAX = 17'h1FFFE;

  // ----------------------------------------------------------------
  // Output-bus selection codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    GPO_DATA = 4'h0,
    GPO_PRESC = 4'h1,
    GPO_LOCK = 4'h2,
    GPO_SLIP = 4'h3,
    GPO_STROBE = 4'h4,
    GPO_ACCUM = 4'h6,
    GPO_AUX = 4'h7,
    GPO_VCO_LE = 4'h9,
    GPO_DSM = 4'hA
  } pdp_gpo_code_t;

endpackage

// [src/pdp_sync.sv]
/*
  Three-stage input synchroniser for a bus of unrelated pin levels.
  Assumes each bit is an independent level; a change is taken only once
  the second and third stages agree.
*/
`timescale 1ns/100ps
`default_nettype none
module pdp_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] st1_reg;
  logic [W-1:0] st2_reg;
  logic [W-1:0] st3_reg;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st1_reg <= '0;
      st2_reg <= '0;
      st3_reg <= '0;
    end
    else
    begin
      st1_reg <= async_in;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
    end
  end

  // A bit moves only when two stages agree, which filters one-cycle glitches.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_out <= '0;
    else
      sync_out <= (st2_reg & st3_reg) | (sync_out & (st2_reg | st3_reg));
  end

endmodule
`default_nettype wire

// [src/pdp_top.sv]
/*
  Digital control of the synthesizer frequency paths: reference choice,
  14-bit reference divider with automatic or manual bypass, modulator
  clock choice, VCO-path divider with fixed divide-by-two and modulator
  driven modulus, and the three-line general purpose output bus.
  Assumes pin levels are slow against ref_clk (at least three cycles per
  level) and that software keeps the configuration it is required to.
*/
// What this block does
// - Square reference input selected after power-up.
// - Reference divider is 14 bits, 1 to 16383.
// - Automatic select overrides manual select bits.
// - Automatic, ratio two up: divided output used.
// - Automatic, ratio one: undivided reference used.
// - Manual: divider runs only with enable set.
// - Manual: output select picks divided or not.
// - Manual: divider may run while bypassed.
// - Modulator may clock from square input.
// - Fixed divide-by-two precedes modulus divider.
// - Fractional ratios even, 72 to 131062.
// - Integer ratios even, 64 to 131070.
// - Fractional ratio deviates at most four.
// - Modulator output sets modulus every cycle.
// - Three-line output bus chosen by field.
// - Output codes map to listed sources.
// - Code zero drives three-bit data field.
`timescale 1ns/100ps
`default_nettype none
module pdp_top
  import pdp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Pin levels
  input wire pdp_pins_t pins,
  // Analog buffer controls
  output logic sin_buf_en,
  output logic square_buffer_enable,
  // Phase detector inputs
  output logic pfd_ref_pulse,
  output logic pfd_vco_pulse,
  // General purpose output bus
  output logic [2:0] gpo_out
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  pdp_ref_cfg_t ref_cfg_reg;
  pdp_ref_div_t ref_div_reg;
  pdp_gpo_cfg_t gpo_cfg_reg;
  logic [16:0] n_ratio_reg;
  logic [23:0] frac_reg;
  logic frac_mode_reg;
  logic [DATA_W-1:0] status;

  logic wr_ref_cfg;
  logic wr_ref_div;
  logic wr_frac;

  assign wr_ref_cfg = reg_wr && (reg_addr == OFF_REF_CFG);
  assign wr_ref_div = reg_wr && (reg_addr == OFF_REF_DIV);
  assign wr_frac = reg_wr && (reg_addr == OFF_FRAC);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_cfg_reg <= REF_CFG_RST;
      ref_div_reg <= REF_DIV_RST;
      gpo_cfg_reg <= GPO_RST;
      n_ratio_reg <= N_RATIO_RST;
      frac_reg <= FRAC_RST;
      frac_mode_reg <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (wr_ref_cfg)
        ref_cfg_reg <= reg_wdata[$bits(pdp_ref_cfg_t)-1:0];
      if (wr_ref_div)
        ref_div_reg <= reg_wdata[15:0];
      if (reg_addr == OFF_N_RATIO)
        n_ratio_reg <= reg_wdata[16:0];
      if (wr_frac)
        frac_reg <= reg_wdata;
      if (reg_addr == OFF_MODE)
        frac_mode_reg <= reg_wdata[0];
      if (reg_addr == OFF_GPO)
        gpo_cfg_reg <= reg_wdata[6:0];
    end
  end

  assign sin_buf_en = ref_cfg_reg.sin_buf_en;
  assign square_buffer_enable = ref_cfg_reg.square_buffer_enable;

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else if (!reg_rd)
      reg_rdata <= '0;
    else
    begin
      unique case (reg_addr)
        OFF_REF_CFG: reg_rdata <= DATA_W'(ref_cfg_reg);
        OFF_REF_DIV: reg_rdata <= DATA_W'(ref_div_reg);
        OFF_N_RATIO: reg_rdata <= DATA_W'(n_ratio_reg);
        OFF_FRAC: reg_rdata <= frac_reg;
        OFF_MODE: reg_rdata <= DATA_W'(frac_mode_reg);
        OFF_STATUS: reg_rdata <= status;
        OFF_GPO: reg_rdata <= DATA_W'(gpo_cfg_reg);
        default: reg_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisation and edges
  // ----------------------------------------------------------------
  pdp_pins_t pin_s;
  pdp_pins_t pin_prev_reg;
  pdp_pins_t pin_rise;

  pdp_sync #(.W(PINS_W)) u_sync
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in(pins),
    .sync_out(pin_s)
  );

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_prev_reg <= '0;
    else
      pin_prev_reg <= pin_s;
  end

  assign pin_rise = pin_s & ~pin_prev_reg;

  // ----------------------------------------------------------------
  // Reference selection and divider
  // ----------------------------------------------------------------
  logic ref_edge;
  logic [13:0] ratio_eff;
  logic ratio_big;
  logic div_run;
  logic route_div;
  logic [13:0] rdiv_cnt_reg;
  logic rdiv_tick;
  logic rdiv_lvl_reg;

  // sine needs sine buffer and mux
  assign ref_edge = ref_cfg_reg.sin_sel
    ? (ref_cfg_reg.sin_buf_en && pin_rise.sine_reference_pin)
    : (ref_cfg_reg.square_buffer_enable && pin_rise.sq_ref);

  assign ratio_eff = (ref_div_reg.ratio == '0) ? REF_RATIO_ONE : ref_div_reg.ratio;
  assign ratio_big = ratio_eff != REF_RATIO_ONE;

  assign div_run = ref_div_reg.auto_sel ? ratio_big : ref_cfg_reg.div_en;
  assign route_div = ref_div_reg.auto_sel ? ratio_big : ref_div_reg.out_sel;
  assign rdiv_tick = div_run && ref_edge && (rdiv_cnt_reg == ratio_eff - 14'h0001);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdiv_cnt_reg <= '0;
    else if (!div_run || wr_ref_div)
      rdiv_cnt_reg <= '0;
    else if (rdiv_tick)
      rdiv_cnt_reg <= '0;
    else if (ref_edge)
      rdiv_cnt_reg <= rdiv_cnt_reg + 14'h0001;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdiv_lvl_reg <= 1'b0;
    else if (!div_run)
      rdiv_lvl_reg <= 1'b0;
    else if (rdiv_tick)
      rdiv_lvl_reg <= ~rdiv_lvl_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pfd_ref_pulse <= 1'b0;
    else
      pfd_ref_pulse <= route_div ? rdiv_tick : ref_edge;
  end

  // ----------------------------------------------------------------
  // Delta-sigma modulator
  // ----------------------------------------------------------------
  logic dsm_edge;
  logic frac_pend_reg;
  logic frac_strobe_reg;
  logic [23:0] frac_act_reg;
  logic [23:0] acc1_reg;
  logic [23:0] acc2_reg;
  logic [24:0] acc1_sum;
  logic [24:0] acc2_sum;
  logic c2_prev_reg;
  logic signed [2:0] dsm_out_reg;

  assign dsm_edge = (ref_cfg_reg.sqr_todig_en && !ref_cfg_reg.dsm_sin_sel) ? pin_rise.sq_ref
    : ref_cfg_reg.dsm_sin_sel ? pin_rise.sine_reference_pin : pfd_ref_pulse;

  // A new fraction waits for a modulator edge; a write in that cycle wins.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frac_pend_reg <= 1'b0;
      frac_strobe_reg <= 1'b0;
      frac_act_reg <= FRAC_RST;
    end
    else
    begin
      frac_strobe_reg <= frac_pend_reg && dsm_edge && !wr_frac;
      if (wr_frac)
        frac_pend_reg <= 1'b1;
      else if (dsm_edge)
        frac_pend_reg <= 1'b0;
      if (frac_pend_reg && dsm_edge && !wr_frac)
        frac_act_reg <= frac_reg;
    end
  end

  assign acc1_sum = {1'b0, acc1_reg} + {1'b0, frac_act_reg};
  assign acc2_sum = {1'b0, acc2_reg} + {1'b0, acc1_sum[23:0]};

  // Two cascaded first-order stages keep the output within -1 to +2.
  // bounded deviation
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc1_reg <= '0;
      acc2_reg <= '0;
      c2_prev_reg <= 1'b0;
      dsm_out_reg <= '0;
    end
    else if (!frac_mode_reg)
    begin
      acc1_reg <= '0;
      acc2_reg <= '0;
      c2_prev_reg <= 1'b0;
      dsm_out_reg <= '0;
    end
    else if (dsm_edge)
    begin
      acc1_reg <= acc1_sum[23:0];
      acc2_reg <= acc2_sum[23:0];
      c2_prev_reg <= acc2_sum[24];
      dsm_out_reg <= 3'($signed({2'b00, acc1_sum[24]}) + $signed({2'b00, acc2_sum[24]})
        - $signed({2'b00, c2_prev_reg}));
    end
  end

  // ----------------------------------------------------------------
  // VCO-path divider
  // ----------------------------------------------------------------
  logic [16:0] n_lim;
  logic n_clamped;
  logic pre2_reg;
  logic pre2_edge;
  logic [15:0] mmd_cnt_reg;
  logic [15:0] modulus;
  logic presc_lvl_reg;

  always_comb
  begin
    n_lim = {n_ratio_reg[16:1], 1'b0};
    n_clamped = 1'b0;
    if (frac_mode_reg && n_lim < N_FRAC_MIN)
    begin
      n_lim = N_FRAC_MIN;
      n_clamped = 1'b1;
    end
    else if (frac_mode_reg && n_lim > N_FRAC_MAX)
    begin
      n_lim = N_FRAC_MAX;
      n_clamped = 1'b1;
    end
    else if (!frac_mode_reg && n_lim < N_INT_MIN)
    begin
      n_lim = N_INT_MIN;
      n_clamped = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      pre2_reg <= 1'b0;
    else if (pin_rise.vco)
      pre2_reg <= ~pre2_reg;
  end

  assign pre2_edge = pin_rise.vco && !pre2_reg;

  assign modulus = n_lim[16:1] + {{13{dsm_out_reg[2]}}, dsm_out_reg};

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mmd_cnt_reg <= '0;
      pfd_vco_pulse <= 1'b0;
      presc_lvl_reg <= 1'b0;
    end
    else
    begin
      pfd_vco_pulse <= pre2_edge && (mmd_cnt_reg == '0);
      if (pre2_edge)
      begin
        if (mmd_cnt_reg == '0)
        begin
          mmd_cnt_reg <= modulus - 16'h0001;
          presc_lvl_reg <= ~presc_lvl_reg;
        end
        else
          mmd_cnt_reg <= mmd_cnt_reg - 16'h0001;
      end
    end
  end

  assign status = DATA_W'({n_clamped, ref_cfg_reg.sin_sel, route_div, div_run});

  // ----------------------------------------------------------------
  // General purpose output bus
  // ----------------------------------------------------------------
  // three-line bus
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      gpo_out <= '0;
    else
    begin
      unique case (gpo_cfg_reg.sel)
        GPO_DATA: gpo_out <= gpo_cfg_reg.data;
        GPO_PRESC: gpo_out <= {pin_s.sq_ref, rdiv_lvl_reg, presc_lvl_reg};
        GPO_LOCK: gpo_out <= {pin_s.pfd_up, pin_s.pfd_dn, pin_s.lock_win};
        GPO_SLIP: gpo_out <= {pin_s.ref_fast, pin_s.vco_fast, pin_s.pfd_strobe};
        GPO_STROBE: gpo_out <= {pin_s.sine_reference_pin, rdiv_lvl_reg, frac_strobe_reg};
        GPO_ACCUM: gpo_out <= acc1_reg[23:21];
        GPO_AUX: gpo_out <= {pin_s.aux_clk, pin_s.ring_osc, dsm_edge};
        GPO_VCO_LE: gpo_out <= pin_s.vco_le;
        GPO_DSM: gpo_out <= dsm_out_reg;
        default: gpo_out <= 3'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

// [dv/pdp_src_model.sv]
/*
  Model of the far-side sources: square and sine references and the VCO.
  Assumes half periods in ref_clk cycles of at least three; zero stops a source.
*/
`timescale 1ns/100ps
`default_nettype none
module pdp_src_model
  import pdp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Half periods
  input wire logic [7:0] sq_half,
  input wire logic [7:0] sin_half,
  input wire logic [7:0] vco_half,
  // Static pin levels and the pins
  input wire logic [10:0] misc,
  output var pdp_pins_t pins
);
  logic [2:0] lvl_reg;
  logic [2:0][7:0] cnt_reg;
  logic [2:0][7:0] half;

  assign half = {vco_half, sq_half, sin_half};
  assign pins = {lvl_reg, misc};

  // A stopped oscillator rests low, so a dead source never shows old edges.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!reset_n || half[i] == 8'h00)
      begin
        lvl_reg[i] <= 1'b0;
        cnt_reg[i] <= 8'h00;
      end
      else if (cnt_reg[i] + 8'h01 >= half[i])
      begin
        lvl_reg[i] <= ~lvl_reg[i];
        cnt_reg[i] <= 8'h00;
      end
      else
        cnt_reg[i] <= cnt_reg[i] + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [dv/pdp_props.sv]
/*
  Port checker of the frequency path control.
  Assumes it is bound to pdp_top and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module pdp_props
  import pdp_pkg::*;
(
  // Clock, reset and register port
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Pins and outputs
  input wire pdp_pins_t pins,
  input wire logic sin_buf_en,
  input wire logic square_buffer_enable,
  input wire logic pfd_ref_pulse,
  input wire logic pfd_vco_pulse,
  input wire logic [2:0] gpo_out
);
  logic [15:0] div_sh;
  pdp_gpo_cfg_t gpo_sh;
  logic sin_sel_sh;
  logic sq_q;
  logic [2:0] vle_q;
  logic [3:0] wr_age;
  logic [3:0] vle_age;
  logic [3:0] sq_age;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Shadows of written fields, as only the ports are visible here.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_sh <= REF_DIV_RST;
      gpo_sh <= GPO_RST;
      sin_sel_sh <= 1'b0;
    end
    else if (reg_wr && reg_addr == OFF_REF_DIV)
      div_sh <= reg_wdata[15:0];
    else if (reg_wr && reg_addr == OFF_GPO)
      gpo_sh <= reg_wdata[6:0];
    else if (reg_wr && reg_addr == OFF_REF_CFG)
      sin_sel_sh <= reg_wdata[3];
  end

  // Saturating ages let in-flight events drain before a check applies.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_age <= 4'h0;
      vle_age <= 4'h0;
      sq_age <= 4'h0;
      vle_q <= 3'h0;
      sq_q <= 1'b0;
    end
    else
    begin
      vle_q <= pins.vco_le;
      sq_q <= pins.sq_ref;
      wr_age <= reg_wr ? 4'h0 : wr_age + {3'h0, wr_age != 4'hF};
      vle_age <= (pins.vco_le != vle_q) ? 4'h0 : vle_age + {3'h0, vle_age != 4'hF};
      sq_age <= (pins.sq_ref && !sq_q) ? 4'h0 : sq_age + {3'h0, sq_age != 4'hF};
    end
  end

  sequence s_cfg_wr;
    reg_wr && reg_addr == OFF_REF_CFG;
  endsequence
  sequence s_div_rd;
    reg_rd && reg_addr == OFF_REF_DIV;
  endsequence

  property p_sq_hold;
    !$stable(square_buffer_enable) |-> $past(reg_wr) && $past(reg_addr) == OFF_REF_CFG;
  endproperty
  property p_cfg_out;
    s_cfg_wr |=> {square_buffer_enable, sin_buf_en} == $past(reg_wdata[1:0]);
  endproperty
  property p_div_rd;
    s_div_rd |=> reg_rdata == {8'h00, div_sh};
  endproperty
  property p_gpo_data;
    gpo_sh.sel == 4'h0 && wr_age >= 4'h3 |-> gpo_out == gpo_sh.data;
  endproperty
  property p_gpo_vle;
    gpo_sh.sel == 4'h9 && wr_age >= 4'h3 && vle_age >= 4'h6 && pins.vco_le == vle_q |-> gpo_out == pins.vco_le;
  endproperty
  property p_ref_cause;
    pfd_ref_pulse && !sin_sel_sh && wr_age >= 4'h8 |-> sq_age inside {[4'h2:4'h7]};
  endproperty
  property p_ref_pulse;
    pfd_ref_pulse && wr_age >= 4'h8 |=> !pfd_ref_pulse [*4];
  endproperty
  property p_vco_pulse;
    pfd_vco_pulse |=> !pfd_vco_pulse [*8];
  endproperty

  a_sq_hold: assert property (p_sq_hold) else $error("square enable moved unwritten");
  a_cfg_out: assert property (p_cfg_out) else $error("buffer enables wrong");
  a_div_rd: assert property (p_div_rd) else $error("divider readback wrong");
  a_gpo_data: assert property (p_gpo_data) else $error("output bus data wrong");
  a_gpo_vle: assert property (p_gpo_vle) else $error("output bus latch enables wrong");
  a_ref_cause: assert property (p_ref_cause) else $error("reference pulse without edge");
  a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse too long");
  a_vco_pulse: assert property (p_vco_pulse) else $error("vco pulse too close");
endmodule

bind pdp_top pdp_props u_props
(
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .sin_buf_en(sin_buf_en),
  .square_buffer_enable(square_buffer_enable), .pfd_ref_pulse(pfd_ref_pulse),
  .pfd_vco_pulse(pfd_vco_pulse), .gpo_out(gpo_out)
);
`default_nettype wire

// [dv/tb.sv]
/*
  Self-checking testbench of the frequency path control.
  Assumes pdp_top, the source model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pdp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [10:0] misc = 11'h000;
  logic [23:0] reg_rdata;
  logic [23:0] d;
  logic [23:0] g;
  pdp_pins_t pins;
  logic sin_buf_en;
  logic square_buffer_enable;
  logic pfd_ref_pulse;
  logic pfd_vco_pulse;
  logic [2:0] gpo_out;
  int n_errors = 0;
  int checks_done = 0;

  always #2 ref_clk = ~ref_clk;

  pdp_top uut
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .sin_buf_en(sin_buf_en),
    .square_buffer_enable(square_buffer_enable), .pfd_ref_pulse(pfd_ref_pulse),
    .pfd_vco_pulse(pfd_vco_pulse), .gpo_out(gpo_out)
  );
  pdp_src_model src
  (
    .ref_clk(ref_clk), .reset_n(reset_n), .sq_half(8'h05), .sin_half(8'h04), .vco_half(8'h03),
    .misc(misc), .pins(pins)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [23:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask

  // Two pulses are skipped so that a restart after a write never shortens the gap.
  task automatic gap(input logic [1:0] s, output logic [23:0] c);
    int n;
    n = 0;
    c = 24'h0;
    while (n < 3 && c < 24'hFA0)
    begin
      @(negedge ref_clk);
      c = c + 24'h1;
      if ((s == 2'h0) ? pfd_ref_pulse : (s == 2'h1) ? pfd_vco_pulse : gpo_out[0])
      begin
        n++;
        if (n < 3)
          c = 24'h0;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({23'h0, square_buffer_enable}, 24'h1);
    rd(OFF_REF_CFG, d);
    chk(d, 24'h000002);
    rd(OFF_REF_DIV, d);
    chk(d, 24'h008001);
    rd(8'h40, d);
    chk(d, 24'h000000);
  endtask

  task automatic t_ref();
    logic [15:0] v [6] = '{16'h8001, 16'h8003, 16'h8000, 16'hC001, 16'h4004, 16'h0004};
    logic [23:0] e [6] = '{24'hA, 24'h1E, 24'hA, 24'hA, 24'h28, 24'hA};
    wr(OFF_REF_CFG, 24'h000006);
    wr(OFF_REF_DIV, 24'h00BFFF);
    rd(OFF_REF_DIV, d);
    chk(d, 24'h00BFFF);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFF_REF_DIV, {8'h00, v[i]});
      gap(2'h0, g);
      chk(g, e[i]);
    end
    rd(OFF_STATUS, d);
    chk({22'h0, d[1:0]}, 24'h1);
    wr(OFF_REF_CFG, 24'h000002);
    wr(OFF_REF_DIV, 24'h004004);
    rd(OFF_STATUS, d);
    chk({23'h0, d[0]}, 24'h0);
    wr(OFF_REF_DIV, 24'h008003);
    gap(2'h0, g);
    chk(g, 24'h1E);
    wr(OFF_REF_DIV, 24'h008001);
  endtask

  task automatic t_sine();
    wr(OFF_REF_CFG, 24'h000009);
    @(negedge ref_clk);
    chk({22'h0, square_buffer_enable, sin_buf_en}, 24'h1);
    gap(2'h0, g);
    chk(g, 24'h8);
    wr(OFF_REF_CFG, 24'h00001B);
    wr(OFF_GPO, 24'h000007);
    gap(2'h2, g);
    chk(g, 24'hA);
    wr(OFF_REF_CFG, 24'h000002);
  endtask

  task automatic t_vco();
    logic [23:0] n [3] = '{24'h42, 24'h0A, 24'h40};
    logic [23:0] e [3] = '{24'h18C, 24'h180, 24'h1B0};
    for (int i = 0; i < 3; i++)
    begin
      wr(OFF_MODE, {23'h0, i == 2});
      wr(OFF_N_RATIO, n[i]);
      gap(2'h1, g);
      chk(g, e[i]);
    end
    wr(OFF_N_RATIO, 24'h64);
    // An eight-cycle modulator clock keeps the divider from always sampling one phase.
    wr(OFF_REF_CFG, 24'h000022);
    wr(OFF_FRAC, 24'h800000);
    d = 24'h0;
    gap(2'h1, g);
    for (int i = 0; i < 6; i++)
    begin
      chk({23'h0, g >= 24'h240 && g <= 24'h270}, 24'h1);
      d = d | {23'h0, g != 24'h258};
      g = 24'h0;
      do
      begin
        @(negedge ref_clk);
        g = g + 24'h1;
      end
      while (!pfd_vco_pulse && g < 24'hFA0);
    end
    chk(d, 24'h1);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFF_GPO, (i == 0) ? 24'h000006 : 24'h00000A);
      repeat (2) @(negedge ref_clk);
      g = 24'h0;
      repeat (24) @(negedge ref_clk) g = g | {21'h0, gpo_out};
      chk(g, (i == 0) ? 24'h4 : 24'h1);
    end
    wr(OFF_MODE, 24'h0);
    wr(OFF_REF_CFG, 24'h000002);
  endtask

  task automatic t_gpo();
    logic [23:0] c [5] = '{24'h50, 24'h09, 24'h02, 24'h03, 24'h05};
    logic [10:0] m [5] = '{11'h000, 11'h006, 11'h600, 11'h0C0, 11'h7FF};
    logic [23:0] x [5] = '{24'h5, 24'h6, 24'h5, 24'h6, 24'h0};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge ref_clk);
      misc <= m[i];
      wr(OFF_GPO, c[i]);
      repeat (10) @(negedge ref_clk);
      chk({21'h0, gpo_out}, x[i]);
    end
  endtask

  initial
  begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_ref();
    t_sine();
    t_vco();
    t_gpo();
    close_out();
  end

  // The scenarios need about 10000 cycles; six times that means a hang.
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
